// ==== rtl/ttxip_top.sv ====
// Overview of operation
// R1 - A request strobe goes to the source, which returns bits after its own pipeline delay.
// R2 - Text starts on both outputs 10.2 us after the hsync leading edge, whatever the delay.
// R3 - The request-to-data delay is a 4-bit setting of 0 to 15 clocks; the source meets it.
// R4 - A zero request-width field keeps the request open for all 360 bits at the text rate.
// R5 - With the enable bit low no request is raised and nothing is inserted.
// R6 - Every group of 37 bits takes exactly 144 clocks, close to four clocks per bit.
// R7 - Bits 10, 19, 28 and 37 of a group last three clocks, all others four, at the source too.
// R8 - The short-bit pattern repeats every 37 bits until the bit count set by the request-width field (at most 360) is done.
// R9 - A sequencer and an interpolating filter soften bit edges before the outputs.
// R10 - All lines use the same timing and insertion is chosen per line from the setup register, for lines 1 to 31 only.
// R11 - The data input is sampled once per bit slot, offset by the delay, else ignored.
`timescale 1ns/1ps
module ttxip_top
    import ttxip_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [APB_AW-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // video timing
    input wire logic HSYNC_I,
    input wire logic VSYNC_I,
    // text source link
    input wire logic TELETEXT_DATA_IN_I,
    output logic TELETEXT_REQUEST_STROBE_O,
    // video outputs
    output logic [9:0] COMPOSITE_OUTPUT_O,
    output logic [9:0] LUMA_O
);

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic ctrl_enable_r;
    logic [3:0] request_width_field_r;
    logic [3:0] request_to_data_delay_r;
    logic [31:0] line_sel_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic hsync_d_r;
    logic [HPOS_W-1:0] hpos_r;
    logic [LINE_W-1:0] line_r;
    logic line_on_r;
    logic cap_over_r;
    logic [8:0] line_lim_r;
    logic [8:0] cap_count_r;
    logic [7:0] ovf_count_r;
    logic req_r;
    logic hold_bit_r;
    logic [9:0] comp_r;
    logic [9:0] luma_r;

    ttxip_fifo_if #(.WIDTH(FIFO_WIDTH)) bitq ();

    ttxip_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .q(bitq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // apb decode
    wire apb_access = PSEL_I & PENABLE_I;
    wire apb_take = apb_access & pready_r;
    wire apb_wr = apb_take & PWRITE_I;
    wire hit_ctrl = (PADDR_I == CTRL_ADDR);
    wire hit_line = (PADDR_I == LINE_SEL_ADDR);
    wire hit_stat = (PADDR_I == STATUS_ADDR);
    wire addr_ok = hit_ctrl | hit_line | hit_stat;
    // status is read only, so writing it is an error too
    wire bad_access = ~addr_ok | (PWRITE_I & hit_stat);

    logic [1:0] seq_run;
    logic [5:0] seq_idx_r [2];
    logic [1:0] seq_sub_r [2];
    logic [8:0] seq_cnt_r [2];
    logic [1:0] seq_start;
    logic [1:0] slot_end;
    logic [1:0] seq_done;

    wire [31:0] ctrl_word = {20'h00000, request_to_data_delay_r, request_width_field_r,
                             3'h0, ctrl_enable_r};
    wire [31:0] stat_word = {line_r, ovf_count_r, 3'h0, cap_count_r, line_on_r,
                             seq_run[1], seq_run[0], req_r};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_word :
                         hit_line ? line_sel_r :
                         hit_stat ? stat_word : 32'h00000000;

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end
        else
        begin
            // one wait state: answer in the second access cycle
            pready_r <= apb_access & ~pready_r;
            pslverr_r <= apb_access & ~pready_r & bad_access;
            prdata_r <= (apb_access & ~pready_r & ~PWRITE_I) ? rd_mux : 32'h00000000;
        end
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            ctrl_enable_r <= 1'b0;
            request_width_field_r <= 4'h0;
            request_to_data_delay_r <= 4'h0;
            line_sel_r <= 32'h00000000;
        end
        else if (apb_wr & hit_ctrl)
        begin
            ctrl_enable_r <= PWDATA_I[CTRL_ENABLE_BIT];
            request_width_field_r <= PWDATA_I[CTRL_WIDTH_LSB +: 4];
            request_to_data_delay_r <= PWDATA_I[CTRL_DELAY_LSB +: 4]; // [R3]
        end
        else if (apb_wr & hit_line)
        begin
            line_sel_r <= line_sel_r ^ (line_sel_r ^ PWDATA_I); // [R10]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // line timing
    wire hsync_edge = HSYNC_I & ~hsync_d_r;
    // selection looks at the line that this sync edge opens
    wire [LINE_W-1:0] line_nxt = (line_r == '1) ? line_r : line_r + 1'b1;
    wire line_chosen = (line_nxt < LINE_SEL_LIMIT) & line_sel_r[line_nxt[4:0]]; // [R10]
    wire [9:0] width_bits = 10'(request_width_field_r * BITS_PER_WIDTH_STEP);
    wire [9:0] lim_calc = ((request_width_field_r == 4'h0) | (width_bits > LINE_BITS)) ?
                          LINE_BITS : width_bits; // [R4]
    // request leads the sampling point by exactly the source delay
    wire [HPOS_W-1:0] req_rise_pos = SAMPLE_START_POS - HPOS_W'(request_to_data_delay_r); // [R2]

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            hsync_d_r <= 1'b0;
            hpos_r <= HPOS_MAX;
            line_r <= '0;
            line_on_r <= 1'b0;
            line_lim_r <= 9'h000;
        end
        else
        begin
            hsync_d_r <= HSYNC_I;
            if (hsync_edge)
                hpos_r <= '0;
            else if (hpos_r != HPOS_MAX)
                hpos_r <= hpos_r + 1'b1;
            if (VSYNC_I)
                line_r <= '0;
            else if (hsync_edge && line_r != '1)
                line_r <= line_r + 1'b1;
            if (!ctrl_enable_r)
                line_on_r <= 1'b0; // [R5]
            else if (hsync_edge)
                line_on_r <= line_chosen;
            if (hsync_edge)
                line_lim_r <= lim_calc[8:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bit slot sequencers: 0 captures, 1 drives the outputs
    assign seq_start[0] = line_on_r & (hpos_r == SAMPLE_START_POS);
    assign seq_start[1] = line_on_r & (hpos_r == OUTPUT_START_POS); // [R2]

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_seq
            assign slot_end[g] = seq_run[g] &
                                 (seq_sub_r[g] == ttxip_last_sub(seq_idx_r[g])); // [R7] [R6]
            assign seq_done[g] = slot_end[g] & (seq_cnt_r[g] == line_lim_r - 1'b1); // [R8]

            always_ff @(posedge SYS_CLK_I)
            begin
                if (RST_I || !ctrl_enable_r)
                begin
                    seq_run[g] <= 1'b0; // [R5]
                    seq_idx_r[g] <= GROUP_FIRST_BIT;
                    seq_sub_r[g] <= 2'h0;
                    seq_cnt_r[g] <= 9'h000;
                end
                else if (seq_start[g])
                begin
                    seq_run[g] <= 1'b1;
                    seq_idx_r[g] <= GROUP_FIRST_BIT;
                    seq_sub_r[g] <= 2'h0;
                    seq_cnt_r[g] <= 9'h000;
                end
                else if (seq_done[g])
                begin
                    seq_run[g] <= 1'b0;
                end
                else if (slot_end[g])
                begin
                    seq_sub_r[g] <= 2'h0;
                    // pattern restarts every 37 bits
                    seq_idx_r[g] <= (seq_idx_r[g] == GROUP_LAST_BIT) ?
                                    GROUP_FIRST_BIT : seq_idx_r[g] + 1'b1; // [R8]
                    seq_cnt_r[g] <= seq_cnt_r[g] + 1'b1;
                end
                else if (seq_run[g])
                begin
                    seq_sub_r[g] <= seq_sub_r[g] + 1'b1;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // capture side
    // mid-slot sample, away from the source's edges
    wire sample_now = seq_run[0] & (seq_sub_r[0] == SAMPLE_SUB); // [R11]
    assign bitq.push_valid = sample_now;
    assign bitq.push_data = TELETEXT_DATA_IN_I;
    // a full fifo drops the request; the bit is lost and counted
    wire req_nxt = line_on_r & ~cap_over_r & ~seq_done[0] & (hpos_r >= req_rise_pos) &
                   bitq.push_ready; // [R1] [R5]

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            req_r <= 1'b0;
            cap_over_r <= 1'b0;
            cap_count_r <= 9'h000;
            ovf_count_r <= 8'h00;
        end
        else
        begin
            req_r <= req_nxt; // [R1] [R4]
            if (hsync_edge)
                cap_over_r <= 1'b0;
            else if (seq_done[0])
                cap_over_r <= 1'b1;
            if (hsync_edge || seq_start[0])
                cap_count_r <= 9'h000;
            else if (sample_now & bitq.push_ready)
                cap_count_r <= cap_count_r + 1'b1;
            if (sample_now & ~bitq.push_ready & (ovf_count_r != 8'hff))
                ovf_count_r <= ovf_count_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output side with edge interpolation
    wire slot_first = seq_run[1] & (seq_sub_r[1] == 2'h0);
    assign bitq.pop_ready = slot_first;
    // an empty fifo plays a zero bit rather than stalling the line
    wire bit_now = slot_first ? (bitq.pop_valid & bitq.pop_data[0]) : hold_bit_r;
    // first cycle of a slot blends the held bit with the new one
    wire [10:0] hold_lvl = ttxip_level(hold_bit_r);
    wire [10:0] mid_sum = hold_lvl + ttxip_level(bit_now);
    wire [9:0] text_lvl = slot_first ? mid_sum[10:1] : hold_lvl[9:0]; // [R9]
    wire [9:0] out_nxt = seq_run[1] ? text_lvl : TEXT_BLANK_LVL; // [R5]

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            hold_bit_r <= 1'b0;
            comp_r <= TEXT_BLANK_LVL;
            luma_r <= TEXT_BLANK_LVL;
        end
        else
        begin
            if (slot_first)
            begin
                hold_bit_r <= bit_now;
            end
            else if (!seq_run[1])
            begin
                hold_bit_r <= 1'b0;
            end
            comp_r <= out_nxt; // [R2]
            luma_r <= out_nxt;
        end
    end

    assign PRDATA_O = prdata_r;
    assign PREADY_O = pready_r;
    assign PSLVERR_O = pslverr_r;
    assign TELETEXT_REQUEST_STROBE_O = req_r;
    assign COMPOSITE_OUTPUT_O = comp_r;
    assign LUMA_O = luma_r;

endmodule // ttxip_top

// ==== rtl/ttxip_pkg.sv ====
package ttxip_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and line timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int SYNC_TO_TEXT_NS = 10200;
    // least time, so rounded up to whole cycles
    localparam int SYNC_TO_TEXT_CYC = (SYNC_TO_TEXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INTERNAL_INSERT_LATENCY_CYC = 16;
    localparam int HPOS_W = 12;
    localparam logic [HPOS_W-1:0] HPOS_MAX = 12'hfff;
    localparam logic [HPOS_W-1:0] SAMPLE_START_POS =
        HPOS_W'(SYNC_TO_TEXT_CYC - INTERNAL_INSERT_LATENCY_CYC);
    localparam logic [HPOS_W-1:0] OUTPUT_START_POS = HPOS_W'(SYNC_TO_TEXT_CYC - 1);

    ////////////////////////////////////////////////////////////////////////////
    // bit slot pattern
    localparam logic [5:0] GROUP_FIRST_BIT = 6'h01;
    localparam logic [5:0] GROUP_LAST_BIT = 6'h25;
    localparam logic [5:0] SHORT_BIT_0 = 6'h0a;
    localparam logic [5:0] SHORT_BIT_1 = 6'h13;
    localparam logic [5:0] SHORT_BIT_2 = 6'h1c;
    localparam logic [5:0] SHORT_BIT_3 = 6'h25;
    localparam logic [1:0] SHORT_LAST_SUB = 2'h2;
    localparam logic [1:0] LONG_LAST_SUB = 2'h3;
    localparam logic [1:0] SAMPLE_SUB = 2'h1;
    localparam logic [9:0] LINE_BITS = 10'h168;
    localparam logic [9:0] BITS_PER_WIDTH_STEP = 10'h025;

    ////////////////////////////////////////////////////////////////////////////
    // output levels
    localparam logic [9:0] TEXT_BLANK_LVL = 10'h100;
    localparam logic [9:0] TEXT_HIGH_LVL = 10'h2a0;

    ////////////////////////////////////////////////////////////////////////////
    // fifo
    localparam int FIFO_WIDTH = 1;
    localparam int FIFO_DEPTH = 16;

    ////////////////////////////////////////////////////////////////////////////
    // register map (byte addresses) and fields
    localparam int APB_AW = 8;
    localparam logic [APB_AW-1:0] CTRL_ADDR = 8'h00;
    localparam logic [APB_AW-1:0] LINE_SEL_ADDR = 8'h04;
    localparam logic [APB_AW-1:0] STATUS_ADDR = 8'h08;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_WIDTH_LSB = 4;
    localparam int CTRL_DELAY_LSB = 8;
    localparam int STAT_REQ_BIT = 0;
    localparam int STAT_CAP_BIT = 1;
    localparam int STAT_OUT_BIT = 2;
    localparam int STAT_LINE_ON_BIT = 3;
    localparam int STAT_COUNT_LSB = 4;
    localparam int STAT_OVF_LSB = 16;
    localparam int STAT_LINE_LSB = 24;
    localparam int LINE_W = 8;
    localparam logic [LINE_W-1:0] LINE_SEL_LIMIT = 8'h20;

    function automatic logic [1:0] ttxip_last_sub(input logic [5:0] idx);
        if (idx == SHORT_BIT_0 || idx == SHORT_BIT_1 || idx == SHORT_BIT_2 ||
            idx == SHORT_BIT_3)
        begin
            return SHORT_LAST_SUB;
        end
        return LONG_LAST_SUB;
    endfunction

    function automatic logic [10:0] ttxip_level(input logic b);
        return {1'b0, (b ? TEXT_HIGH_LVL : TEXT_BLANK_LVL)};
    endfunction

endpackage

// ==== rtl/ttxip_fifo_if.sv ====
`timescale 1ns/1ps
interface ttxip_fifo_if #(parameter int WIDTH = 1);
    logic push_valid;
    logic push_ready;
    logic [WIDTH-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [WIDTH-1:0] pop_data;

    modport user (output push_valid, output push_data, input push_ready,
                  input pop_valid, input pop_data, output pop_ready);
    modport store (input push_valid, input push_data, output push_ready,
                   output pop_valid, output pop_data, input pop_ready);
endinterface

// ==== rtl/ttxip_fifo.sv ====
`timescale 1ns/1ps
module ttxip_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    ttxip_fifo_if.store q
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] count_r;

    wire do_push = q.push_valid & q.push_ready;
    wire do_pop = q.pop_valid & q.pop_ready;

    assign q.push_ready = (count_r != (PW+1)'(DEPTH));
    assign q.pop_valid = (count_r != '0);
    assign q.pop_data = mem_r[rd_ptr_r];

    always_ff @(posedge clk_i)
    begin
        if (do_push)
        begin
            mem_r[wr_ptr_r] <= q.push_data;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (do_push)
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            if (do_pop)
                rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            count_r <= count_r + (PW+1)'(do_push) - (PW+1)'(do_pop);
        end
    end
endmodule // ttxip_fifo

// ==== testbench/ttxip_tb_pkg.sv ====
package ttxip_tb_pkg;

    function automatic int slot_len(int k);
        int r;
        r = k % 37;
        return (r == 10 || r == 19 || r == 28 || r == 0) ? 3 : 4;
    endfunction

    function automatic int slot_start(int k);
        int s;
        s = 0;
        for (int j = 1; j < k; j++)
            s += slot_len(j);
        return s;
    endfunction

endpackage

// ==== testbench/ttxip_source_model.sv ====
`timescale 1ns/1ps
module ttxip_source_model
    import ttxip_tb_pkg::*;
(
    // link
    input wire logic clk_i,
    input wire logic strobe_i,
    output logic data_o,
    // set-up from the bench
    input wire logic [3:0] delay_i,
    input wire logic [31:0] pattern_i
);
    int cyc_r;
    bit idle_r;
    int q;
    int k;
    int s;

    // zero in the first open cycle
    always @(posedge clk_i)
    begin
        cyc_r <= strobe_i ? cyc_r + 1 : 0;
        idle_r <= !idle_r;
    end

    // each bit spans its slot, starting one cycle early, so that it covers the sample point
    always @*
    begin
        q = cyc_r - int'(delay_i);
        k = 0;
        s = -1;
        for (int j = 1; j <= 360 && k == 0; j++)
        begin
            if (q >= s && q < s + slot_len(j))
                k = j;
            s += slot_len(j);
        end
        // nothing owed: toggle so a stale bit can never pass
        data_o = (strobe_i && k != 0) ? pattern_i[k % 32] : idle_r;
    end
endmodule // ttxip_source_model

// ==== testbench/ttxip_properties.sv ====
`timescale 1ns/1ps
module ttxip_props_chk
    import ttxip_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [APB_AW-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic HSYNC_I,
    input wire logic TELETEXT_REQUEST_STROBE_O,
    input wire logic [9:0] COMPOSITE_OUTPUT_O,
    input wire logic [9:0] LUMA_O
);
    logic hs_q;
    logic en_r;
    logic [3:0] dly_r;
    logic [HPOS_W-1:0] hcnt_r;
    logic [HPOS_W-1:0] hcnt_nxt;
    logic ctrl_wr;

    // hcnt is 1 at the edge that sees the sync rise
    assign ctrl_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == CTRL_ADDR;
    assign hcnt_nxt = (HSYNC_I && !hs_q) ? 12'h001 : hcnt_r + 12'(hcnt_r != HPOS_MAX);

    always_ff @(posedge SYS_CLK_I)
    begin
        hs_q <= RST_I ? 1'b0 : HSYNC_I;
        hcnt_r <= RST_I ? HPOS_MAX : hcnt_nxt;
        en_r <= RST_I ? 1'b0 : (ctrl_wr ? PWDATA_I[CTRL_ENABLE_BIT] : en_r);
        dly_r <= RST_I ? 4'h0 : (ctrl_wr ? PWDATA_I[CTRL_DELAY_LSB +: 4] : dly_r);
    end

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    property p_rdy_wait;
        PSEL_I && PENABLE_I && !$past(PENABLE_I) |-> !PREADY_O ##1 PREADY_O;
    endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("ready not one wait state");
    property p_rdy_pulse;
        PREADY_O |=> !PREADY_O;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than a cycle");
    property p_err_rdy;
        PSLVERR_O |-> PREADY_O;
    endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
    property p_luma;
        LUMA_O == COMPOSITE_OUTPUT_O;
    endproperty
    a_luma: assert property (p_luma) else $error("luma differs from composite");
    property p_off;
        !en_r && !$past(en_r) && !$past(en_r, 2) |-> !TELETEXT_REQUEST_STROBE_O
            && COMPOSITE_OUTPUT_O == TEXT_BLANK_LVL;
    endproperty
    a_off: assert property (p_off) else $error("activity while disabled");
    property p_str_pos;
        $rose(TELETEXT_REQUEST_STROBE_O) |->
            int'(hcnt_r) == int'(SAMPLE_START_POS) + 2 - int'(dly_r);
    endproperty
    a_str_pos: assert property (p_str_pos) else $error("request opened at wrong time");
    property p_blank_pre;
        hcnt_r >= 12'h002 && hcnt_r <= OUTPUT_START_POS + 12'h002
            |-> COMPOSITE_OUTPUT_O == TEXT_BLANK_LVL;
    endproperty
    a_blank_pre: assert property (p_blank_pre) else $error("text before its offset");
    property p_str_min;
        $rose(TELETEXT_REQUEST_STROBE_O) |-> TELETEXT_REQUEST_STROBE_O[*8];
    endproperty
    a_str_min: assert property (p_str_min) else $error("request window too short");
endmodule // ttxip_props_chk

bind ttxip_top ttxip_props_chk u_props (.SYS_CLK_I, .RST_I, .PSEL_I, .PENABLE_I,
    .PWRITE_I, .PADDR_I, .PWDATA_I, .PREADY_O, .PSLVERR_O, .HSYNC_I,
    .TELETEXT_REQUEST_STROBE_O, .COMPOSITE_OUTPUT_O, .LUMA_O);

// ==== testbench/tb_teletext_insertion_port.sv ====
`timescale 1ns/1ps
module tb_teletext_insertion_port
    import ttxip_pkg::*, ttxip_tb_pkg::*;
();
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic hsync = 1'b0;
    logic vsync = 1'b0;
    logic ttx_in;
    logic strobe;
    logic [9:0] comp;
    logic [9:0] luma;
    logic [3:0] dly = 4'h0;
    logic [31:0] pat = 32'h0;
    int mismatches = 0;
    int checks_done = 0;

    always #20 clk = ~clk;

    ttxip_top uut (
        .SYS_CLK_I(clk),
        .RST_I(rst),
        .PSEL_I(psel),
        .PENABLE_I(penable),
        .PWRITE_I(pwrite),
        .PADDR_I(paddr),
        .PWDATA_I(pwdata),
        .PRDATA_O(prdata),
        .PREADY_O(pready),
        .PSLVERR_O(pslverr),
        .HSYNC_I(hsync),
        .VSYNC_I(vsync),
        .TELETEXT_DATA_IN_I(ttx_in),
        .TELETEXT_REQUEST_STROBE_O(strobe),
        .COMPOSITE_OUTPUT_O(comp),
        .LUMA_O(luma)
    );

    ttxip_source_model src (
        .clk_i(clk),
        .strobe_i(strobe),
        .data_o(ttx_in),
        .delay_i(dly),
        .pattern_i(pat)
    );

    ////////////////////////////////////////////////////////////
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // on a read, d is the expected data under mask m
    task automatic xfer(logic wr, logic [7:0] a, logic [31:0] d, logic [31:0] m, logic eerr);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        if (!wr)
            check("prdata", d, prdata & m);
        check("pslverr", 32'(eerr), 32'(pslverr));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // j counts edges from the one that sees the sync rise
    task automatic run_line(int d, int n, logic on, int ln);
        int rise;
        int fall;
        int k;
        int t;
        logic [9:0] prev;
        logic [9:0] lvl;
        logic [9:0] exp;
        rise = 0;
        fall = 0;
        k = 1;
        prev = TEXT_BLANK_LVL;
        @(posedge clk);
        hsync <= 1'b1;
        for (int j = 1; j <= 1800; j++)
        begin
            @(posedge clk);
            hsync <= (j < 20);
            @(negedge clk);
            rise = (rise == 0 && strobe === 1'b1) ? j : rise;
            fall = (rise != 0 && fall == 0 && strobe !== 1'b1) ? j : fall;
            // sequencer start and output register each add a cycle
            t = j - int'(OUTPUT_START_POS) - 3;
            if (!on || (j >= 2 && t < 0))
                check("blank", 32'(TEXT_BLANK_LVL), 32'(comp));
            else if (t >= 0 && k <= n)
            begin
                lvl = pat[k % 32] ? TEXT_HIGH_LVL : TEXT_BLANK_LVL;
                exp = t == slot_start(k) ? 10'((11'(prev) + lvl) / 2) : lvl;
                check("level", 32'(exp), 32'(comp));
                if (t == slot_start(k + 1) - 1)
                begin
                    prev = lvl;
                    k++;
                end
            end
        end
        check("rise", on ? 32'(int'(SAMPLE_START_POS) + 2 - d) : 32'h0, 32'(rise));
        // request closes at the end of the last slot
        check("open", on ? 32'(slot_start(n + 1) + d) : 32'h0, 32'(fall - rise));
        xfer(1'b0, STATUS_ADDR, {8'(ln), 11'h0, 9'(on * n), 4'h0}, 32'hfffffff0, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////
    initial
    begin
        int d;
        int w;
        int n;
        logic en;
        logic [31:0] cfg;
        void'($urandom(32'he58a));
        pat = $urandom();
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        xfer(1'b0, CTRL_ADDR, 32'h0, 32'hffffffff, 1'b0);
        xfer(1'b0, LINE_SEL_ADDR, 32'h0, 32'hffffffff, 1'b0);
        xfer(1'b0, STATUS_ADDR, 32'h0, 32'hffffffff, 1'b0);
        xfer(1'b0, 8'h0c, 32'h0, 32'hffffffff, 1'b1);
        xfer(1'b1, STATUS_ADDR, 32'hffffffff, 32'h0, 1'b1);
        xfer(1'b0, STATUS_ADDR, 32'h0, 32'hffffffff, 1'b0);
        xfer(1'b1, LINE_SEL_ADDR, 32'h000000de, 32'h0, 1'b0);
        xfer(1'b0, LINE_SEL_ADDR, 32'h000000de, 32'hffffffff, 1'b0);
        @(posedge clk);
        vsync <= 1'b1;
        @(posedge clk);
        vsync <= 1'b0;
        // line 5 unselected, line 7 selected but disabled
        for (int i = 1; i <= 7; i++)
        begin
            d = (i == 1) ? 0 : (i == 2) ? 15 : $urandom_range(15);
            w = (i == 1) ? 0 : (i == 2) ? 10 : (i == 3) ? 1 : $urandom_range(9);
            en = (i != 7);
            n = (w == 0 || w * 37 > 360) ? 360 : w * 37;
            cfg = (32'(d) << CTRL_DELAY_LSB) | (32'(w) << CTRL_WIDTH_LSB) | 32'(en);
            dly <= 4'(d);
            xfer(1'b1, CTRL_ADDR, cfg, 32'h0, 1'b0);
            xfer(1'b0, CTRL_ADDR, cfg, 32'hffffffff, 1'b0);
            run_line(d, n, en && i != 5, i);
        end
        test_done();
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        mismatches++;
        $display("[FAIL] watchdog expected done seen timeout");
        test_done();
    end
endmodule // tb_teletext_insertion_port
